// file: hdl/cmofr_pkg.sv
// Constants for the message object tag, mask, length and data page.
// Assumes one clock and an eight-bit register port owned by the core.

package cmofr_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int         MOB_COUNT = 6;
  localparam logic [3:0] MAX_LEN   = 4'h8;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_PAGE  = 8'h00;
  localparam logic [7:0] ADDR_STAT  = 8'h01;
  localparam logic [7:0] ADDR_LEN   = 8'h02;
  localparam logic [7:0] ADDR_TAG1  = 8'h03;
  localparam logic [7:0] ADDR_TAG4  = 8'h06;
  localparam logic [7:0] ADDR_MSK1  = 8'h07;
  localparam logic [7:0] ADDR_MSK4  = 8'h0A;
  localparam logic [7:0] ADDR_STML  = 8'h0B;
  localparam logic [7:0] ADDR_STMH  = 8'h0C;
  localparam logic [7:0] ADDR_MSG   = 8'h0D;
  localparam logic [7:0] ADDR_RXEN  = 8'h0E;
  localparam logic [7:0] ADDR_AREP  = 8'h0F;
  localparam logic [7:0] ADDR_ISTAT = 8'h10;
  localparam logic [7:0] ADDR_IMASK = 8'h11;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int PAGE_OBJ_LSB  = 4;
  localparam int PAGE_INDEX_AUTOINC_DISABLE_BIT = 3;
  localparam int STAT_WARN_BIT = 7;
  localparam int LEN_FMT_BIT   = 4;
  localparam int TAG_RTR_BIT   = 2;
  localparam int MSK_IDE_BIT   = 0;

  // Compared tag bits: standard 31:21 and 2, extended 31:2.
  localparam logic [31:0] STD_CMP = 32'hFFE0_0004;
  localparam logic [31:0] EXT_CMP = 32'hFFFF_FFFC;

endpackage

// file: hdl/cmofr_top.sv
// Message object page: tag, mask, length, stamp and data of six objects,
// acceptance filtering of received frames and transmit field supply.
// Assumes the protocol engine presents one received frame per rxValid pulse
// and pulses txLoad before it needs the fields of an object.
// Assumes software writes zero to the unused standard tag and mask bits.

`timescale 1ns/1ns

module cmofr_top
  import cmofr_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // Register port
  input  wire logic [7:0]  regAddr,
  input  wire logic [7:0]  regWdata,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [7:0]  regRdata,
  // Received frame
  input  wire logic        rxValid,
  input  wire logic [28:0] rxId,
  input  wire logic        rxIde,
  input  wire logic        rxRtr,
  input  wire logic        rxRb1,
  input  wire logic        rxRb0,
  input  wire logic [3:0]  rxLen,
  input  wire logic [63:0] rxData,
  input  wire logic [15:0] rxStamp,
  // Transmit fields
  input  wire logic        txLoad,
  input  wire logic [2:0]  txObj,
  output logic      [31:0] txTag,
  output logic             txIde,
  output logic      [3:0]  txLen,
  output logic      [63:0] txData,
  // Automatic reply request
  output logic             replyReq,
  output logic      [2:0]  replyObj,
  // Interrupt
  output logic             irq
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------

  // Length code as a byte count.
  // Only transmit clamps the code, so the warning still sees the raw value.
  function automatic logic [3:0] effLen(input logic [3:0] code);
    effLen = (code > MAX_LEN) ? MAX_LEN : code;
  endfunction

  // Bit position of tag or mask byte k, byte 1 being the top.
  function automatic logic [4:0] bytePos(input logic [7:0] off);
    logic [1:0] k;
    k = off[1:0];
    bytePos = {~k, 3'b000};
  endfunction

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // Object arrays carry no reset and read unknown until written or received.
  // Page, enables and flags do reset, so software starts from a known page.
  logic [31:0] tag_r   [MOB_COUNT];
  logic [31:0] mask_r  [MOB_COUNT];
  logic [3:0]  len_r   [MOB_COUNT];
  logic        fmt_r   [MOB_COUNT];
  logic [15:0] stamp_r [MOB_COUNT];
  logic [63:0] dat_r   [MOB_COUNT];

  // Page select, per-object enables and flags.
  logic [3:0]           pageObj_r;
  logic                 aincDis_r;
  logic [2:0]           pageIdx_r;
  logic [MOB_COUNT-1:0] warn_r;
  logic [MOB_COUNT-1:0] rxEn_r;
  logic [MOB_COUNT-1:0] autoRep_r;
  logic [MOB_COUNT-1:0] iStat_r;
  logic [MOB_COUNT-1:0] iMask_r;
  logic [7:0]           regRdata_r;
  logic [31:0]          txTag_r;
  logic                 txIde_r;
  logic [3:0]           txLen_r;
  logic [63:0]          txData_r;
  logic                 replyReq_r;
  logic [2:0]           replyObj_r;
  logic                 irq_r;

  // ----------------------------------------------------------------
  // Address decoding
  // ----------------------------------------------------------------
  // Object registers are refused while the page names an object past the last.
  wire logic [2:0] selIdx = pageObj_r[2:0];
  wire logic       selOk  = (pageObj_r < 4'(MOB_COUNT));

  wire logic isTag = (regAddr >= ADDR_TAG1) && (regAddr <= ADDR_TAG4);
  wire logic isMsk = (regAddr >= ADDR_MSK1) && (regAddr <= ADDR_MSK4);
  wire logic [7:0] tagOff = regAddr - ADDR_TAG1;
  wire logic [7:0] mskOff = regAddr - ADDR_MSK1;
  wire logic [4:0] tagPos = bytePos(tagOff);
  wire logic [4:0] mskPos = bytePos(mskOff);
  wire logic [5:0] msgPos = {pageIdx_r, 3'b000};

  // Write and read strokes, each qualified by its address.
  wire logic wrPage = regWrite && (regAddr == ADDR_PAGE);
  wire logic wrStat = regWrite && (regAddr == ADDR_STAT) && selOk;
  wire logic wrLen  = regWrite && (regAddr == ADDR_LEN) && selOk;
  wire logic wrTag  = regWrite && isTag && selOk;
  wire logic wrMsk  = regWrite && isMsk && selOk;
  wire logic wrMsg  = regWrite && (regAddr == ADDR_MSG) && selOk;
  wire logic rdMsg  = regRead && (regAddr == ADDR_MSG) && selOk;
  wire logic wrRxEn = regWrite && (regAddr == ADDR_RXEN);
  wire logic wrARep = regWrite && (regAddr == ADDR_AREP);
  wire logic wrIStt = regWrite && (regAddr == ADDR_ISTAT);
  wire logic wrIMsk = regWrite && (regAddr == ADDR_IMASK);

  // ----------------------------------------------------------------
  // Acceptance filter
  // ----------------------------------------------------------------

  // Received frame laid out as a tag word.
  // Standard frames load the unused bits with zero, so a received tag can be
  // sent again without software tidying it first.
  wire logic [31:0] rxWordExt = {rxId, rxRtr, rxRb1, rxRb0};
  wire logic [31:0] rxWordStd = {rxId[10:0], 18'h0, rxRtr, 1'b0, rxRb0};
  wire logic [31:0] rxWord    = rxIde ? rxWordExt : rxWordStd;

  logic [MOB_COUNT-1:0] hit;

  genvar g;
  generate
    for (g = 0; g < MOB_COUNT; g++) begin : gFilt
      // Standard layout leaves bits 20:3, 1 and 0 out of the compare.
      // The format bit is compared apart, under the mask's extension bit.
      wire logic [31:0] cmp  = fmt_r[g] ? EXT_CMP : STD_CMP;
      wire logic [31:0] diff = (rxWord ^ tag_r[g]) & mask_r[g] & cmp;
      wire logic fmtBad = mask_r[g][MSK_IDE_BIT] && (rxIde != fmt_r[g]);
      assign hit[g] = rxEn_r[g] && (diff == 32'h0) && !fmtBad;
    end
  endgenerate

  // The lowest object index takes the frame.
  // Scanning downwards lets the lowest hit overwrite every higher one.
  logic [2:0] win;
  always_comb begin
    win = 3'h0;
    for (int i = MOB_COUNT - 1; i >= 0; i--) begin
      if (hit[i]) begin
        win = 3'(i);
      end
    end
  end

  // Only the winning object may answer a remote frame.
  wire logic rxTake = rxValid && (hit != '0);
  wire logic doRep  = rxTake && rxRtr && autoRep_r[win];

  // The request bit is dropped from the stored tag for an object that will answer itself.
  wire logic [31:0] rxStore = doRep ?
                              (rxWord & ~(32'h1 << TAG_RTR_BIT)) : rxWord;

  // ----------------------------------------------------------------
  // Object storage, no reset
  // ----------------------------------------------------------------

  // A frame landing in the selected object wins over a software write.
  // Software sees the reception in the status flag and may rewrite the field.
  always_ff @(posedge clock) begin
    for (int i = 0; i < MOB_COUNT; i++) begin
      if (rxTake && (win == 3'(i))) begin
        tag_r[i]   <= rxStore;
        fmt_r[i]   <= rxIde;
        len_r[i]   <= rxLen;
        stamp_r[i] <= rxStamp;
        dat_r[i]   <= rxData;
      end else if (selIdx == 3'(i)) begin
        if (wrTag) begin
          tag_r[i][tagPos +: 8] <= regWdata;
        end
        if (wrLen) begin
          len_r[i] <= regWdata[3:0];
          fmt_r[i] <= regWdata[LEN_FMT_BIT];
        end
        if (wrMsg) begin
          dat_r[i][msgPos +: 8] <= regWdata;
        end
      end
    end
  end

  // Reception never loads the mask, so software owns it outright.
  always_ff @(posedge clock) begin
    for (int i = 0; i < MOB_COUNT; i++) begin
      if (wrMsk && (selIdx == 3'(i))) begin
        mask_r[i][mskPos +: 8] <= regWdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Page select and byte index
  // ----------------------------------------------------------------
  // A page write loads the index; unless the page write set the disable bit, each data
  // byte access then steps it, and the three-bit counter wraps from seven back to zero by itself.
  wire logic idxStep = (wrMsg || rdMsg) && !aincDis_r;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pageObj_r <= 4'h0;
      aincDis_r <= 1'b0;
      pageIdx_r <= 3'h0;
    end else if (wrPage) begin
      pageObj_r <= regWdata[7:PAGE_OBJ_LSB];
      aincDis_r <= regWdata[PAGE_INDEX_AUTOINC_DISABLE_BIT];
      pageIdx_r <= regWdata[2:0];
    end else if (idxStep) begin
      pageIdx_r <= pageIdx_r + 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // Sticky flags and interrupt
  // ----------------------------------------------------------------
  logic [MOB_COUNT-1:0] warnSet;
  logic [MOB_COUNT-1:0] takeSet;
  logic [MOB_COUNT-1:0] warnClr;

  generate
    for (g = 0; g < MOB_COUNT; g++) begin : gFlag
      wire logic mine = rxTake && (win == 3'(g));
      assign takeSet[g] = mine;
      // Raw codes are compared, so nine against eight still warns.
      assign warnSet[g] = mine && (rxLen != len_r[g]);
      assign warnClr[g] = wrStat && (selIdx == 3'(g)) && regWdata[STAT_WARN_BIT];
    end
  endgenerate

  // Set wins over a clear in the same cycle, so an event is never lost to a
  // clear that software issued for an older one.
  wire logic [MOB_COUNT-1:0] warnNxt = (warn_r & ~warnClr) | warnSet;
  wire logic [MOB_COUNT-1:0] iClr    = wrIStt ? regWdata[MOB_COUNT-1:0] : '0;
  wire logic [MOB_COUNT-1:0] iStatNxt = (iStat_r & ~iClr) | takeSet;
  wire logic [MOB_COUNT-1:0] iMaskNxt = wrIMsk ? regWdata[MOB_COUNT-1:0] : iMask_r;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      warn_r  <= '0;
      iStat_r <= '0;
      iMask_r <= '0;
      irq_r   <= 1'b0;
    end else begin
      warn_r  <= warnNxt;
      iStat_r <= iStatNxt;
      iMask_r <= iMaskNxt;
      // Built from the next values, the interrupt moves on the same edge as its flag.
      irq_r   <= (iStatNxt & iMaskNxt) != '0;
    end
  end

  // Receive and reply enables start closed, so no frame lands before setup.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rxEn_r    <= '0;
      autoRep_r <= '0;
    end else begin
      if (wrRxEn) begin
        rxEn_r <= regWdata[MOB_COUNT-1:0];
      end
      if (wrARep) begin
        autoRep_r <= regWdata[MOB_COUNT-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Read data stand one cycle and are zero otherwise, so a stale byte cannot
  // pass for an answer.
  logic [7:0] rdNxt;
  wire logic [31:0] selTag = tag_r[selIdx];
  wire logic [31:0] selMsk = mask_r[selIdx];
  wire logic [15:0] selStm = stamp_r[selIdx];
  wire logic [63:0] selDat = dat_r[selIdx];

  always_comb begin
    rdNxt = 8'h00;
    if (regAddr == ADDR_PAGE) begin
      rdNxt = {pageObj_r, aincDis_r, pageIdx_r};
    end else if (regAddr == ADDR_RXEN) begin
      rdNxt = 8'(rxEn_r);
    end else if (regAddr == ADDR_AREP) begin
      rdNxt = 8'(autoRep_r);
    end else if (regAddr == ADDR_ISTAT) begin
      rdNxt = 8'(iStat_r);
    end else if (regAddr == ADDR_IMASK) begin
      rdNxt = 8'(iMask_r);
    end else if (!selOk) begin
      rdNxt = 8'h00;
    end else if (regAddr == ADDR_STAT) begin
      rdNxt = {warn_r[selIdx], 7'h00};
    end else if (regAddr == ADDR_LEN) begin
      rdNxt = {3'h0, fmt_r[selIdx], len_r[selIdx]};
    end else if (isTag) begin
      rdNxt = selTag[tagPos +: 8];
    end else if (isMsk) begin
      rdNxt = selMsk[mskPos +: 8];
    end else if (regAddr == ADDR_STML) begin
      rdNxt = selStm[7:0];
    end else if (regAddr == ADDR_STMH) begin
      rdNxt = selStm[15:8];
    end else if (regAddr == ADDR_MSG) begin
      rdNxt = selDat[msgPos +: 8];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      regRdata_r <= 8'h00;
    end else begin
      regRdata_r <= regRead ? rdNxt : 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Transmit fields and automatic reply
  // ----------------------------------------------------------------
  // An object number past the last leaves the transmit fields as they were.
  wire logic txOk = txLoad && (txObj < 3'(MOB_COUNT));

  // A load copies one object whole, so the fields sent always belong together.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      txTag_r  <= 32'h0;
      txIde_r  <= 1'b0;
      txLen_r  <= 4'h0;
      txData_r <= 64'h0;
    end else if (txOk) begin
      txTag_r  <= tag_r[txObj];
      txIde_r  <= fmt_r[txObj];
      txLen_r  <= effLen(len_r[txObj]);
      txData_r <= dat_r[txObj];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      replyReq_r <= 1'b0;
      replyObj_r <= 3'h0;
    end else begin
      replyReq_r <= doRep;
      // The object number holds after the pulse so the engine may fetch it late.
      replyObj_r <= doRep ? win : replyObj_r;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Every output is a register copy; nothing combinational reaches a pin.
  assign regRdata = regRdata_r;
  assign txTag    = txTag_r;
  assign txIde    = txIde_r;
  assign txLen    = txLen_r;
  assign txData   = txData_r;
  assign replyReq = replyReq_r;
  assign replyObj = replyObj_r;
  assign irq      = irq_r;

endmodule

// file: verif/cmofr_assertions.sv
// Checker for the message object page, bound to its top module.
// Assumes software writes zero to the unused standard tag bits.
`timescale 1ns/1ns
module cmofr_assertions
  import cmofr_pkg::*;
(
  // Clock and reset
  input wire logic        clock,
  input wire logic        rst,
  // Register port
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic [7:0]  regRdata,
  // Frame side
  input wire logic        rxValid,
  input wire logic        rxRtr,
  input wire logic        txLoad,
  input wire logic [31:0] txTag,
  input wire logic        txIde,
  input wire logic [3:0]  txLen,
  input wire logic        replyReq,
  input wire logic [2:0]  replyObj,
  input wire logic        irq
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  a_read_window: assert property (regRdata != 8'h00 |-> $past(regRead))
    else $error("read data outside its cycle");
  a_len_clamp: assert property ($past(txLoad) |-> txLen <= MAX_LEN)
    else $error("transmit length above eight");
  a_tx_hold: assert property (!$past(txLoad) |-> $stable(txTag) && $stable(txLen))
    else $error("transmit fields moved without load");
  a_std_zero: assert property (!txIde |-> txTag[20:3] == 18'h0 && !txTag[1])
    else $error("standard tag unused bits not zero");
  a_reply_cause: assert property (replyReq |-> $past(rxValid && rxRtr))
    else $error("reply request without remote frame");
  a_reply_obj: assert property (!replyReq |-> $stable(replyObj))
    else $error("reply object moved without request");
  a_irq_rise: assert property ($rose(irq) |-> $past(rxValid) || $past(regWrite)
    || $past(regWrite, 2))
    else $error("interrupt rose without cause");
  a_irq_fall: assert property ($fell(irq) |-> $past(regWrite) || $past(regWrite, 2))
    else $error("interrupt fell without write");
endmodule

bind cmofr_top cmofr_assertions i_cmofr_assertions (
  .clock, .rst, .regWrite, .regRead, .regRdata, .rxValid, .rxRtr, .txLoad,
  .txTag, .txIde, .txLen, .replyReq, .replyObj, .irq
);

// file: verif/cmofr_can_node.sv
// Remote CAN node model presenting received frames to the object page.
// Assumes sendFrame is called from the bench just after a rising edge.
`timescale 1ns/1ns
module cmofr_can_node (
  // Clock
  input  wire logic        clock,
  // Received frame
  output logic             rxValid,
  output logic      [28:0] rxId,
  output logic             rxIde,
  output logic             rxRtr,
  output logic             rxRb1,
  output logic             rxRb0,
  output logic      [3:0]  rxLen,
  output logic      [63:0] rxData,
  output logic      [15:0] rxStamp
);
  initial begin
    rxValid = 1'b0;
    {rxId, rxIde, rxRtr, rxRb1, rxRb0, rxLen, rxData, rxStamp} = '0;
  end
  task automatic sendFrame(input logic [28:0] id, input logic ide, input logic rtr,
                           input logic rb1, input logic rb0, input logic [3:0] len,
                           input logic [63:0] data, input logic [15:0] stamp);
    @(posedge clock);
    rxValid <= 1'b1;
    rxId    <= id;
    {rxIde, rxRtr, rxRb1, rxRb0} <= {ide, rtr, rb1, rb0};
    {rxLen, rxData, rxStamp} <= {len, data, stamp};
    @(posedge clock);
    rxValid <= 1'b0;
    // Released fields show the inverse so stale values cannot pass as live.
    {rxId, rxIde, rxRtr, rxRb1, rxRb0, rxLen, rxData, rxStamp} <=
      ~{rxId, rxIde, rxRtr, rxRb1, rxRb0, rxLen, rxData, rxStamp};
  endtask
endmodule

// file: verif/test_can_msg_object_id_filter_regs.sv
// Bench for the message object page: filter rows, then reception, data
// window, transmit, interrupt and refused accesses.
// Assumes the node model drives every received frame input.
`timescale 1ns/1ns
module test_can_msg_object_id_filter_regs
  import cmofr_pkg::*;
;
  logic        clock, rst, regWrite, regRead, txLoad;
  logic        rxValid, rxIde, rxRtr, rxRb1, rxRb0, txIde, replyReq, irq;
  logic [7:0]  regAddr, regWdata, regRdata;
  logic [2:0]  txObj, replyObj;
  logic [3:0]  rxLen, txLen;
  logic [28:0] rxId;
  logic [31:0] txTag;
  logic [63:0] rxData, txData;
  logic [15:0] rxStamp;
  int          failCount = 0;
  int          cmpCount = 0;
  int          cycles = 0;
  localparam logic [31:0] TAGX = 32'h0D5E_6F7B;
  localparam logic [63:0] DATX = 64'h8877_6655_4433_2211;
  typedef struct packed {
    logic [31:0] tag;
    logic [31:0] msk;
    logic        fmt;
    logic [28:0] id;
    logic        ide;
    logic        rtr;
    logic        hit;
  } cmofr_row_t;
  localparam cmofr_row_t ROWS [10] = '{
    '{32'h2460_0000, 32'hFFE0_0005, 1'b0, 29'h0000123, 1'b0, 1'b0, 1'b1},
    '{32'h2460_0000, 32'hFFE0_0005, 1'b0, 29'h0000122, 1'b0, 1'b0, 1'b0},
    '{32'h2460_0000, 32'h0000_0001, 1'b0, 29'h00007FF, 1'b0, 1'b0, 1'b1},
    '{32'h2460_0000, 32'hFFE0_0005, 1'b0, 29'h0000123, 1'b0, 1'b1, 1'b0},
    '{32'h2460_0000, 32'hFFE0_0001, 1'b0, 29'h0000123, 1'b0, 1'b1, 1'b1},
    '{32'h2460_0000, 32'hFFE0_0005, 1'b0, 29'h48C0000, 1'b1, 1'b0, 1'b0},
    '{32'h2460_0000, 32'hFFE0_0004, 1'b0, 29'h48C0000, 1'b1, 1'b0, 1'b1},
    '{32'h091A_2B38, 32'hFFFF_FFFD, 1'b1, 29'h1234567, 1'b1, 1'b0, 1'b1},
    '{32'h091A_2B38, 32'hFFFF_FFFD, 1'b1, 29'h1234566, 1'b1, 1'b0, 1'b0},
    '{32'h091A_2B38, 32'hFFFF_FFF5, 1'b1, 29'h1234566, 1'b1, 1'b0, 1'b1}
  };

  cmofr_top i_cmofr_top (
    .clock, .rst, .regAddr, .regWdata, .regWrite, .regRead, .regRdata, .rxValid,
    .rxId, .rxIde, .rxRtr, .rxRb1, .rxRb0, .rxLen, .rxData, .rxStamp, .txLoad,
    .txObj, .txTag, .txIde, .txLen, .txData, .replyReq, .replyObj, .irq
  );
  cmofr_can_node i_cmofr_can_node (
    .clock, .rxValid, .rxId, .rxIde, .rxRtr, .rxRb1, .rxRb0, .rxLen, .rxData, .rxStamp
  );

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failCount = failCount + 1;
      testDone();
    end
  end

  task automatic chk(input string n, input logic [63:0] seen, input logic [63:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      failCount++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    regAddr  <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask
  // Read data are sampled mid-cycle, the only cycle in which they stand.
  task automatic rc(input logic [7:0] a, input logic [7:0] e, input string n);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    #20 chk(n, regRdata, e);
  endtask
  task automatic tx(input logic [2:0] o);
    @(posedge clock);
    txObj  <= o;
    txLoad <= 1'b1;
    @(posedge clock);
    txLoad <= 1'b0;
    #20;
  endtask
  task automatic setObj(input logic [2:0] o, input logic [31:0] t, input logic [31:0] m,
                        input logic [7:0] lf);
    wr(ADDR_PAGE, {1'b0, o, 4'h0});
    wr(ADDR_LEN, lf);
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_TAG1 + 8'(k), t[31-8*k -: 8]);
      wr(ADDR_MSK1 + 8'(k), m[31-8*k -: 8]);
    end
  endtask
  task automatic testDone();
    if (failCount == 0 && cmpCount > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    rst = 1'b1;
    {regAddr, regWdata, regWrite, regRead, txLoad, txObj} = '0;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    #20 chk("irq", irq, 1'b0);
    chk("txLen", txLen, 4'h0);
    rc(ADDR_PAGE, 8'h00, "page");
    rc(ADDR_ISTAT, 8'h00, "istat");
    wr(ADDR_RXEN, 8'h01);
    wr(ADDR_IMASK, 8'h01);
    foreach (ROWS[i]) begin
      setObj(3'h0, ROWS[i].tag, ROWS[i].msk, {3'h0, ROWS[i].fmt, 4'h2});
      i_cmofr_can_node.sendFrame(ROWS[i].id, ROWS[i].ide, ROWS[i].rtr, 1'b0, 1'b0,
                                 4'h2, 64'h0, 16'h0);
      rc(ADDR_ISTAT, {7'h0, ROWS[i].hit}, "hit");
      chk("irq", irq, ROWS[i].hit);
      wr(ADDR_ISTAT, 8'h01);
    end
    setObj(3'h1, 32'h0000_0000, 32'h0000_0001, 8'h12);
    wr(ADDR_RXEN, 8'h02);
    wr(ADDR_AREP, 8'h02);
    i_cmofr_can_node.sendFrame(29'h1ABCDEF, 1'b1, 1'b1, 1'b1, 1'b1, 4'h4, DATX, 16'hBEEF);
    #20 chk("reply", replyReq, 1'b1);
    chk("replyObj", replyObj, 3'h1);
    for (int k = 0; k < 4; k++) begin
      rc(ADDR_TAG1 + 8'(k), TAGX[31-8*k -: 8], "tag");
    end
    rc(ADDR_STAT, 8'h80, "warning");
    rc(ADDR_LEN, 8'h14, "length");
    wr(ADDR_STAT, 8'h80);
    rc(ADDR_STAT, 8'h00, "warning");
    rc(ADDR_STMH, 8'hBE, "stampH");
    wr(ADDR_STML, 8'h00);
    rc(ADDR_STML, 8'hEF, "stampL");
    wr(ADDR_PAGE, 8'h16);
    for (int k = 0; k < 3; k++) begin
      rc(ADDR_MSG, DATX[8*((6+k)%8) +: 8], "data");
    end
    wr(ADDR_PAGE, 8'h1A);
    wr(ADDR_MSG, 8'hA5);
    rc(ADDR_MSG, 8'hA5, "data");
    rc(ADDR_MSG, 8'hA5, "data");
    wr(ADDR_LEN, 8'h1B);
    tx(3'h1);
    chk("txLen", txLen, 4'h8);
    chk("txTag", txTag, TAGX);
    chk("txIde", txIde, 1'b1);
    chk("txData", txData, 64'h8877_6655_44A5_2211);
    tx(3'h6);
    chk("txTag", txTag, TAGX);
    chk("irq", irq, 1'b0);
    wr(ADDR_IMASK, 8'h02);
    rc(ADDR_ISTAT, 8'h02, "istat");
    chk("irq", irq, 1'b1);
    wr(ADDR_ISTAT, 8'h02);
    rc(ADDR_ISTAT, 8'h00, "istat");
    chk("irq", irq, 1'b0);
    wr(8'h20, 8'hFF);
    rc(8'h20, 8'h00, "unmapped");
    wr(ADDR_PAGE, 8'h60);
    rc(ADDR_TAG1, 8'h00, "noObject");
    // A second reset in mid-run clears the page, enables and transmit fields.
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    #20 chk("txTag", txTag, 32'h0);
    chk("replyObj", replyObj, 3'h0);
    rc(ADDR_PAGE, 8'h00, "page");
    rc(ADDR_RXEN, 8'h00, "rxEnable");
    // Standard frame into an open object: unused bits load zero, rb1 is dropped.
    wr(ADDR_RXEN, 8'h01);
    setObj(3'h0, 32'h0000_0000, 32'h0000_0000, 8'h05);
    i_cmofr_can_node.sendFrame(29'h1555_5555, 1'b0, 1'b0, 1'b1, 1'b1, 4'h5, DATX, 16'h1234);
    rc(ADDR_STAT, 8'h00, "warning");
    tx(3'h0);
    chk("txTag", txTag, 32'hAAA0_0001);
    chk("txIde", txIde, 1'b0);
    chk("txLen", txLen, 4'h5);
    testDone();
  end
endmodule
